// ==== csbr_sysbus.sv ====
// CPU-side system bus port: issues reads and writes, returns read data
`timescale 1ns/10ps
module csbr_sysbus
  import csbr_pkg::*;
(
  input wire logic core_clk_i,                       // System clock
  input wire logic reset_i,                          // Async reset, active high
  input wire logic req_valid_i,                      // Request pending
  input wire logic req_write_i,                      // 1 write, 0 read
  input wire logic req_block_i,                      // 1 block, 0 doubleword or less
  input wire logic [2:0] req_size_i,                 // Block length or bytes minus one
  input wire logic [PA_W-1:0] req_addr_i,            // Physical address
  output logic req_ready_o,                          // Request taken this cycle
  input wire logic [AD_W-1:0] wr_data_i,             // Write data
  input wire logic wr_valid_i,                       // Write data present
  output logic wr_ready_o,                           // Write data taken
  output logic [AD_W-1:0] rd_data_o,                 // Read data
  output logic rd_valid_o,                           // Read data pulse
  output logic rd_last_o,                            // Final element of read
  output logic rd_bus_error_o,                       // Agent flagged error
  output logic rd_check_error_o,                     // Check or parity fault
  output logic [2:0] rd_cache_state_o,               // Returned cache state
  input wire logic [AD_W-1:0] addr_data_bus_i,       // Bus in
  output logic [AD_W-1:0] addr_data_bus_o,           // Bus out
  output logic addr_data_bus_oe_o,                   // Bus drive enable
  input wire logic [CHK_W-1:0] addr_data_check_bits_i, // Check bits in
  output logic [CHK_W-1:0] addr_data_check_bits_o,   // Check bits out
  output logic addr_data_check_bits_oe_o,            // Check bits drive enable
  input wire logic [CMD_W-1:0] command_bus_i,        // Command in
  output logic [CMD_W-1:0] command_bus_o,            // Command out
  output logic command_bus_oe_o,                     // Command drive enable
  input wire logic command_parity_bit_i,             // Parity in
  output logic command_parity_bit_o,                 // Parity out
  output logic command_parity_bit_oe_o,              // Parity drive enable
  output logic cpu_valid_out_o,                      // CPU drives valid cycle
  input wire logic agent_valid_in_i,                 // Agent drives valid cycle
  input wire logic read_accept_i,                    // Agent can take a read
  input wire logic write_accept_i,                   // Agent can take a write
  output logic release_o                             // Bus released next clock
);

  ////////////////////////////////////////////////////////////////////////////
  // State and accept pipelines

  csbr_state_t state;
  logic rd_acc_q1;
  logic rd_acc_q2;
  logic wr_acc_q1;
  logic wr_acc_q2;
  logic bus_oe;
  logic [CNT_W-1:0] wr_left;
  logic rd_ok;
  logic wr_ok;
  logic take_req;
  logic take_wr;
  logic rx_hit;
  logic data_bad;
  logic cmd_bad;
  logic [AD_W-1:0] next_bus_data;
  logic [CMD_W-1:0] next_bus_cmd;
  logic [CMD_W-1:0] req_cmd;
  logic [CNT_W-1:0] req_count;
  logic wr_last;

  csbr_id_if id_f ();

  csbr_id_decode u_id_decode (
    .cmd_i(command_bus_i),
    .id(id_f)
  );

  csbr_rx_check u_rx_check (
    .data_i(addr_data_bus_i),
    .check_i(addr_data_check_bits_i),
    .cmd_i(command_bus_i),
    .parity_i(command_parity_bit_i),
    .data_bad_o(data_bad),
    .cmd_bad_o(cmd_bad)
  );

  // Accept inputs are sampled twice, so a change acts two clocks later
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_acc_q1 <= 1'b0;
      rd_acc_q2 <= 1'b0;
      wr_acc_q1 <= 1'b0;
      wr_acc_q2 <= 1'b0;
    end else begin
      rd_acc_q1 <= read_accept_i;
      rd_acc_q2 <= rd_acc_q1;
      wr_acc_q1 <= write_accept_i;
      wr_acc_q2 <= wr_acc_q1;
    end
  end

  assign rd_ok = rd_acc_q2;
  assign wr_ok = wr_acc_q2;
  assign req_ready_o = (state == ST_IDLE) && (req_write_i ? wr_ok : rd_ok);
  assign take_req = req_valid_i && req_ready_o;
  assign wr_ready_o = (state == ST_WR_DATA);
  assign take_wr = wr_valid_i && wr_ready_o;
  assign wr_last = (wr_left == ONE_DWORD);
  // Any valid-in data response cycle in ST_RD_WAIT is accepted; the agent sets the pace
  assign rx_hit = (state == ST_RD_WAIT) && agent_valid_in_i && id_f.is_data
                  && id_f.response;

  ////////////////////////////////////////////////////////////////////////////
  // Command encoding

  always_comb begin
    req_cmd = csbr_make_cmd(req_write_i ? REQ_WRITE : REQ_READ,
                            req_block_i ? ATTR_BLOCK : ATTR_DWORD,
                            req_block_i ? {1'b0, req_size_i[1:0]}
                                        : req_size_i);
    // Block of 4<<n words is 2<<n doublewords
    req_count = req_block_i ? (BLK_DWORDS_BASE << req_size_i[1:0]) : ONE_DWORD;
  end

  always_comb begin
    next_bus_data = AD_ZERO;
    next_bus_cmd = '0;
    if (state == ST_IDLE && take_req) begin
      next_bus_data = {UPPER_ZERO, req_addr_i};
      next_bus_cmd = req_cmd;
    end else if (take_wr) begin
      next_bus_data = wr_data_i;
      next_bus_cmd = {TYPE_DATA, ~wr_last, 1'b1, 1'b0, 1'b0, 4'h0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus drive, registered at the pins

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      addr_data_bus_o <= AD_ZERO;
      addr_data_check_bits_o <= '0;
      command_bus_o <= '0;
      command_parity_bit_o <= 1'b0;
    end else begin
      addr_data_bus_o <= next_bus_data;
      addr_data_check_bits_o <= csbr_lane_parity(next_bus_data);
      command_bus_o <= next_bus_cmd;
      command_parity_bit_o <= ^next_bus_cmd;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cpu_valid_out_o <= 1'b0;
      release_o <= 1'b0;
    end else begin
      cpu_valid_out_o <= (state == ST_IDLE && take_req) || take_wr;
      // Release rides with the read command; buses float next clock
      release_o <= (state == ST_IDLE) && take_req && !req_write_i;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      bus_oe <= 1'b1;
    end else if (release_o) begin
      bus_oe <= 1'b0;
    end else if (state == ST_TURN) begin
      bus_oe <= 1'b1;
    end
  end

  assign addr_data_bus_oe_o = bus_oe;
  assign addr_data_check_bits_oe_o = bus_oe;
  assign command_bus_oe_o = bus_oe;
  assign command_parity_bit_oe_o = bus_oe;

  ////////////////////////////////////////////////////////////////////////////
  // Transaction sequencing

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (take_req) begin
            state <= req_write_i ? ST_WR_DATA : ST_RD_WAIT;
          end
        end
        ST_RD_WAIT: begin
          // Errors do not end the read; only the last identifier does
          if (rx_hit && id_f.last) begin
            state <= ST_TURN;
          end
        end
        ST_TURN: begin
          state <= ST_IDLE;
        end
        ST_WR_DATA: begin
          if (take_wr && wr_last) begin
            state <= ST_WR_END;
          end
        end
        ST_WR_END: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_left <= '0;
    end else if (state == ST_IDLE && take_req) begin
      wr_left <= req_count;
    end else if (take_wr) begin
      wr_left <= wr_left - ONE_DWORD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read return capture

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_data_o <= AD_ZERO;
      rd_valid_o <= 1'b0;
      rd_last_o <= 1'b0;
      rd_bus_error_o <= 1'b0;
      rd_check_error_o <= 1'b0;
      rd_cache_state_o <= CS_INVALID;
    end else begin
      rd_valid_o <= rx_hit;
      if (rx_hit) begin
        rd_data_o <= addr_data_bus_i;
        rd_last_o <= id_f.last;
        rd_bus_error_o <= id_f.error;
        rd_check_error_o <= (data_bad && !id_f.no_check) || cmd_bad;
        rd_cache_state_o <= id_f.cache_state;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_upper_zero: assert property (@(posedge core_clk_i) disable iff (reset_i)
    cpu_valid_out_o && !command_bus_o[CMD_TYPE_BIT] |-> addr_data_bus_o[AD_W-1:PA_W] == '0)
    else $error("address phase upper bits not zero");

  a_check_bits: assert property (@(posedge core_clk_i) disable iff (reset_i)
    bus_oe |-> addr_data_check_bits_o == csbr_lane_parity(addr_data_bus_o))
    else $error("outgoing check bits wrong");

  a_cmd_parity: assert property (@(posedge core_clk_i) disable iff (reset_i)
    bus_oe |-> command_parity_bit_o == ^command_bus_o)
    else $error("command parity not even");

  a_idle_quiet: assert property (@(posedge core_clk_i) disable iff (reset_i)
    bus_oe && !cpu_valid_out_o |-> addr_data_bus_o == AD_ZERO && command_bus_o == '0)
    else $error("bus carries content outside a valid cycle");

  a_read_gate: assert property (@(posedge core_clk_i) disable iff (reset_i)
    take_req && !req_write_i |-> $past(read_accept_i, 2))
    else $error("read issued without accept two clocks back");

  a_release_float: assert property (@(posedge core_clk_i) disable iff (reset_i)
    release_o |-> bus_oe ##1 !bus_oe)
    else $error("release not followed by tri-state");

  a_release_cmd: assert property (@(posedge core_clk_i) disable iff (reset_i)
    release_o |-> cpu_valid_out_o && command_bus_o[7:5] == REQ_READ)
    else $error("release without read command");

  a_write_valid: assert property (@(posedge core_clk_i) disable iff (reset_i)
    take_wr |=> cpu_valid_out_o && command_bus_o[CMD_TYPE_BIT] && bus_oe)
    else $error("write data without valid-out");

  a_rx_capture: assert property (@(posedge core_clk_i) disable iff (reset_i)
    rx_hit |=> rd_valid_o && rd_data_o == $past(addr_data_bus_i))
    else $error("read return not captured");

  a_last_turn: assert property (@(posedge core_clk_i) disable iff (reset_i)
    rd_valid_o && rd_last_o |-> state == ST_TURN ##1 bus_oe)
    else $error("last element did not end the read");

  a_err_flag: assert property (@(posedge core_clk_i) disable iff (reset_i)
    rd_valid_o |-> rd_bus_error_o == $past(command_bus_i[ID_ERR_BIT]))
    else $error("bus error flag mismatch");

  a_wr_id_fields: assert property (@(posedge core_clk_i) disable iff (reset_i)
    take_wr |=> command_bus_o[ID_RESP_BIT] && !command_bus_o[ID_ERR_BIT])
    else $error("write data identifier fields wrong");

  a_wr_last_id: assert property (@(posedge core_clk_i) disable iff (reset_i)
    take_wr |=> command_bus_o[ID_LAST_BIT] == !$past(wr_last))
    else $error("write word last marking wrong");

  a_write_hold: assert property (@(posedge core_clk_i) disable iff (reset_i)
    take_req && req_write_i |=> !release_o && bus_oe)
    else $error("write released the bus");

  a_refuse_quiet: assert property (@(posedge core_clk_i) disable iff (reset_i)
    state == ST_IDLE && !take_req |=> !cpu_valid_out_o)
    else $error("command shown without an accepted request");

  a_rx_last: assert property (@(posedge core_clk_i) disable iff (reset_i)
    rx_hit |=> rd_last_o == !$past(command_bus_i[ID_LAST_BIT]))
    else $error("last flag of read return wrong");

  a_rx_state: assert property (@(posedge core_clk_i) disable iff (reset_i)
    rx_hit |=> rd_cache_state_o == $past(command_bus_i[2:0]))
    else $error("cache state of read return wrong");

endmodule : csbr_sysbus

// ==== csbr_pkg.sv ====
// Shared constants, types and helpers for the CPU system bus read/write port
package csbr_pkg;
  localparam int AD_W = 64;
  localparam int CHK_W = 8;
  localparam int CMD_W = 9;
  localparam int PA_W = 36;
  localparam int ZERO_W = 28;
  localparam int CNT_W = 5;
  localparam int ACCEPT_DELAY = 2;
  // Command and data identifier bit positions
  localparam int CMD_TYPE_BIT = 8;
  localparam int ID_LAST_BIT = 7;
  localparam int ID_RESP_BIT = 6;
  localparam int ID_ERR_BIT = 5;
  localparam int ID_NOCHK_BIT = 4;
  localparam logic TYPE_COMMAND = 1'h0;
  localparam logic TYPE_DATA = 1'h1;
  localparam logic [2:0] REQ_READ = 3'h0;
  localparam logic [2:0] REQ_READ_WFWD = 3'h1;
  localparam logic [2:0] REQ_WRITE = 3'h2;
  localparam logic [1:0] ATTR_BLOCK = 2'h2;
  localparam logic [1:0] ATTR_DWORD = 2'h3;
  localparam logic [2:0] CS_INVALID = 3'h0;
  localparam logic [2:0] CS_CLEAN_EXCL = 3'h4;
  localparam logic [2:0] CS_DIRTY_EXCL = 3'h5;
  localparam logic [2:0] CS_SHARED = 3'h6;
  localparam logic [2:0] CS_DIRTY_SHARED = 3'h7;
  localparam logic [CNT_W-1:0] BLK_DWORDS_BASE = 5'h02;
  localparam logic [CNT_W-1:0] ONE_DWORD = 5'h01;
  localparam logic [AD_W-1:0] AD_ZERO = 64'h0;
  localparam logic [ZERO_W-1:0] UPPER_ZERO = 28'h0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RD_WAIT = 3'b001,
    ST_TURN = 3'b010,
    ST_WR_DATA = 3'b011,
    ST_WR_END = 3'b100
  } csbr_state_t;

  // Even parity per byte lane
  function automatic logic [CHK_W-1:0] csbr_lane_parity(input logic [AD_W-1:0] d);
    logic [CHK_W-1:0] p;
    p = '0;
    for (int i = 0; i < CHK_W; i++) begin
      p[i] = ^d[i*8 +: 8];
    end
    return p;
  endfunction : csbr_lane_parity

  function automatic logic [CMD_W-1:0] csbr_make_cmd(input logic [2:0] req,
                                                     input logic [1:0] attr,
                                                     input logic [2:0] low);
    return {TYPE_COMMAND, req, attr, low};
  endfunction : csbr_make_cmd
endpackage : csbr_pkg

// ==== csbr_id_if.sv ====
// Decoded fields of an incoming data identifier
`timescale 1ns/10ps
interface csbr_id_if;
  logic is_data;
  logic last;
  logic response;
  logic error;
  logic no_check;
  logic [2:0] cache_state;
  modport dec (output is_data, last, response, error, no_check, cache_state);
  modport use_side (input is_data, last, response, error, no_check, cache_state);
endinterface : csbr_id_if

// ==== csbr_id_decode.sv ====
// Field decoder for data identifiers arriving on the command bus
`timescale 1ns/10ps
module csbr_id_decode
  import csbr_pkg::*;
(
  input wire logic [CMD_W-1:0] cmd_i, // Incoming command bus
  csbr_id_if.dec id                   // Decoded identifier fields
);
  assign id.is_data = (cmd_i[CMD_TYPE_BIT] == TYPE_DATA);
  assign id.last = ~cmd_i[ID_LAST_BIT];
  assign id.response = ~cmd_i[ID_RESP_BIT];
  assign id.error = cmd_i[ID_ERR_BIT];
  assign id.no_check = cmd_i[ID_NOCHK_BIT];
  assign id.cache_state = cmd_i[2:0];
endmodule : csbr_id_decode

// ==== csbr_rx_check.sv ====
// Check-bit and command parity checker for incoming cycles
`timescale 1ns/10ps
module csbr_rx_check
  import csbr_pkg::*;
(
  input wire logic [AD_W-1:0] data_i,   // Incoming address/data
  input wire logic [CHK_W-1:0] check_i, // Incoming check bits
  input wire logic [CMD_W-1:0] cmd_i,   // Incoming command bus
  input wire logic parity_i,            // Incoming command parity
  output logic data_bad_o,              // Check bits mismatch
  output logic cmd_bad_o                // Command parity mismatch
);
  assign data_bad_o = (csbr_lane_parity(data_i) != check_i);
  assign cmd_bad_o = ((^cmd_i) != parity_i);
endmodule : csbr_rx_check

// ==== csbr_agent_model.sv ====
// Behavioural memory agent answering CPU reads on the system bus
`timescale 1ns/10ps
module csbr_agent_model
  import csbr_pkg::*;
(
  input wire logic core_clk_i, // Clock
  input wire logic reset_i, // Reset
  input wire logic [AD_W-1:0] cpu_ad_i, // CPU bus out
  input wire logic [CMD_W-1:0] cpu_cmd_i, // CPU command out
  input wire logic cpu_oe_i, // CPU drives
  input wire logic cpu_valid_out_i, // CPU valid cycle
  input wire logic err_i, // First element erroneous
  input wire logic no_check_i, // Ask CPU not to check
  input wire logic bad_chk_i, // Corrupt check bits
  input wire logic gap_i, // Idle cycle between elements
  input wire logic [2:0] cstate_i, // Cache state returned
  output logic [AD_W-1:0] ad_o, // Bus drive
  output logic [CHK_W-1:0] chk_o, // Check bits drive
  output logic [CMD_W-1:0] cmd_o, // Identifier drive
  output logic par_o, // Parity drive
  output logic valid_in_o // Agent valid cycle
);
  logic [32:0] start_dw;
  logic [5:0] left;
  logic [5:0] idx;
  logic busy;
  logic [CMD_W-1:0] id;
  logic [AD_W-1:0] d;

  function automatic logic [CHK_W-1:0] lane_par(input logic [AD_W-1:0] v);
    logic [CHK_W-1:0] p;
    for (int i = 0; i < CHK_W; i++) begin
      p[i] = ^v[i*8 +: 8];
    end
    return p;
  endfunction : lane_par

  function automatic logic [AD_W-1:0] elem(input logic [32:0] dw, input logic [5:0] k);
    return {8'hA5, 20'h0, dw ^ {27'h0, k}, 3'h0};
  endfunction : elem

  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      busy <= 1'b0;
      valid_in_o <= 1'b0;
      ad_o <= 64'h0;
      chk_o <= 8'h0;
      cmd_o <= 9'h0;
      par_o <= 1'b0;
      left <= 6'h0;
      idx <= 6'h0;
      start_dw <= 33'h0;
    end else begin
      valid_in_o <= 1'b0;
      // Released lines keep changing so a stale value never looks valid
      ad_o <= ~ad_o;
      chk_o <= ~chk_o;
      cmd_o <= ~cmd_o;
      par_o <= ~par_o;
      if (cpu_valid_out_i && cpu_cmd_i[8] == TYPE_COMMAND && cpu_cmd_i[7:5] == REQ_READ) begin
        start_dw <= cpu_ad_i[35:3];
        left <= (cpu_cmd_i[4:3] == ATTR_DWORD) ? 6'h1 : (6'h2 << cpu_cmd_i[1:0]);
        idx <= 6'h0;
        busy <= 1'b1;
      end else if (busy && !cpu_oe_i && (!gap_i || !valid_in_o)) begin
        id = {TYPE_DATA, left != 6'h1, 1'b0, err_i && idx == 6'h0, no_check_i, 1'b0, cstate_i};
        d = elem(start_dw, idx);
        valid_in_o <= 1'b1;
        ad_o <= d;
        chk_o <= bad_chk_i ? ~lane_par(d) : lane_par(d);
        cmd_o <= id;
        par_o <= ^id;
        idx <= idx + 6'h1;
        left <= left - 6'h1;
        busy <= left != 6'h1;
      end
    end
  end
endmodule : csbr_agent_model

// ==== cpu_system_bus_read_protocol_test.sv ====
// Self-checking bench for the CPU system bus port
`timescale 1ns/10ps
module cpu_system_bus_read_protocol_test;
  import csbr_pkg::*;
  logic core_clk_i, reset_i, req_valid_i, req_write_i, req_block_i, wr_valid_i;
  logic read_accept_i, write_accept_i, err, nchk, bchk, gap, req_ready_o, wr_ready_o;
  logic rd_valid_o, rd_last_o, rd_bus_error_o, rd_check_error_o, release_o;
  logic ad_oe, chk_oe, cmd_oe, par_oe, cpu_valid_out_o, valid_in, par_o, ag_par;
  logic [2:0] req_size_i, cstate, rd_cache_state_o;
  logic [PA_W-1:0] req_addr_i;
  logic [AD_W-1:0] wr_data_i, rd_data_o, ad_o, ag_ad;
  logic [CHK_W-1:0] chk_o, ag_chk;
  logic [CMD_W-1:0] cmd_o, ag_cmd;
  int n_errors = 0;
  int checked = 0;

  csbr_sysbus csbr_sysbus_inst (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .req_valid_i(req_valid_i), .req_write_i(req_write_i), .req_block_i(req_block_i),
    .req_size_i(req_size_i), .req_addr_i(req_addr_i), .req_ready_o(req_ready_o),
    .wr_data_i(wr_data_i), .wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o),
    .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .rd_last_o(rd_last_o),
    .rd_bus_error_o(rd_bus_error_o), .rd_check_error_o(rd_check_error_o),
    .rd_cache_state_o(rd_cache_state_o), .addr_data_bus_i(ad_oe ? ad_o : ag_ad),
    .addr_data_bus_o(ad_o), .addr_data_bus_oe_o(ad_oe),
    .addr_data_check_bits_i(chk_oe ? chk_o : ag_chk), .addr_data_check_bits_o(chk_o),
    .addr_data_check_bits_oe_o(chk_oe), .command_bus_i(cmd_oe ? cmd_o : ag_cmd),
    .command_bus_o(cmd_o), .command_bus_oe_o(cmd_oe),
    .command_parity_bit_i(par_oe ? par_o : ag_par), .command_parity_bit_o(par_o),
    .command_parity_bit_oe_o(par_oe), .cpu_valid_out_o(cpu_valid_out_o),
    .agent_valid_in_i(valid_in), .read_accept_i(read_accept_i),
    .write_accept_i(write_accept_i), .release_o(release_o));

  csbr_agent_model csbr_agent_model_inst (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .cpu_ad_i(ad_o), .cpu_cmd_i(cmd_o), .cpu_oe_i(ad_oe), .cpu_valid_out_i(cpu_valid_out_o),
    .err_i(err), .no_check_i(nchk), .bad_chk_i(bchk), .gap_i(gap), .cstate_i(cstate),
    .ad_o(ag_ad), .chk_o(ag_chk), .cmd_o(ag_cmd), .par_o(ag_par), .valid_in_o(valid_in));

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic check(input string what, input logic [AD_W-1:0] seen, input logic [AD_W-1:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_sim();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  task automatic hang();
    n_errors++;
    end_sim();
  endtask : hang

  task automatic issue(input logic wr, input logic blk, input logic [2:0] sz, input logic [PA_W-1:0] a);
    int t;
    logic [CMD_W-1:0] c;
    t = 0;
    c = {TYPE_COMMAND, wr ? REQ_WRITE : REQ_READ, blk ? ATTR_BLOCK : ATTR_DWORD, sz};
    {req_write_i, req_block_i, req_size_i, req_addr_i, req_valid_i} = {wr, blk, sz, a, 1'b1};
    while (req_ready_o !== 1'b1 && t < 50) begin
      @(negedge core_clk_i);
      t++;
    end
    if (t == 50) hang();
    @(negedge core_clk_i);
    req_valid_i = 1'b0;
    check("cmd", cmd_o, c);
    check("par", par_o, ^c);
    check("addr", ad_o, {UPPER_ZERO, a});
    check("chk", chk_o, csbr_agent_model_inst.lane_par({UPPER_ZERO, a}));
    check("vout", cpu_valid_out_o, 1'b1);
    check("rel", release_o, !wr);
  endtask : issue

  task automatic read_run(input logic blk, input logic [2:0] sz, input logic [PA_W-1:0] a,
                          input logic e, input logic nc, input logic bc, input logic g,
                          input logic [2:0] cs);
    int n, k, t;
    n = blk ? (2 << sz[1:0]) : 1;
    k = 0;
    t = 0;
    {err, nchk, bchk, gap, cstate} = {e, nc, bc, g, cs};
    issue(1'b0, blk, sz, a);
    @(negedge core_clk_i);
    check("oe", {ad_oe, chk_oe, cmd_oe, par_oe}, 4'h0);
    while (k < n && t < 300) begin
      if (rd_valid_o === 1'b1) begin
        check("rdata", rd_data_o, csbr_agent_model_inst.elem(a[35:3], k[5:0]));
        check("berr", rd_bus_error_o, e && k == 0);
        check("cerr", rd_check_error_o, bc && !nc);
        check("cstate", rd_cache_state_o, cs);
        check("last", rd_last_o, k == n - 1);
        k++;
      end
      @(negedge core_clk_i);
      t++;
    end
    if (t == 300) hang();
    repeat (3) @(negedge core_clk_i);
    check("oe_back", {ad_oe, chk_oe, cmd_oe, par_oe}, 4'hF);
  endtask : read_run

  task automatic write_run(input logic blk, input logic [2:0] sz, input logic [PA_W-1:0] a);
    int n, t;
    n = blk ? (2 << sz[1:0]) : 1;
    issue(1'b1, blk, sz, a);
    wr_valid_i = 1'b1;
    for (int i = 0; i < n; i++) begin
      wr_data_i = 64'hC0DE_5A5A_0000_0000 + i;
      t = 0;
      while (wr_ready_o !== 1'b1 && t < 20) begin
        @(negedge core_clk_i);
        t++;
      end
      if (t == 20) hang();
      @(negedge core_clk_i);
      check("wdata", ad_o, 64'hC0DE_5A5A_0000_0000 + i);
      check("wchk", chk_o, csbr_agent_model_inst.lane_par(64'hC0DE_5A5A_0000_0000 + i));
      check("wid", cmd_o, {TYPE_DATA, i != n - 1, 1'b1, 6'h0});
      check("wvout", cpu_valid_out_o, 1'b1);
    end
    wr_valid_i = 1'b0;
    check("wrdy", wr_ready_o, 1'b0);
  endtask : write_run

  // Accept low must hold the request off; raising it frees ready two clocks later
  task automatic refuse(input logic wr);
    if (wr) write_accept_i = 1'b0;
    else read_accept_i = 1'b0;
    repeat (3) @(negedge core_clk_i);
    {req_write_i, req_block_i, req_size_i, req_addr_i, req_valid_i} = {wr, 1'b0, 3'h7, 36'h0, 1'b1};
    repeat (4) begin
      @(negedge core_clk_i);
      check("hold", {req_ready_o, cpu_valid_out_o}, 2'h0);
    end
    {read_accept_i, write_accept_i} = 2'h3;
    @(negedge core_clk_i);
    check("rdy1", req_ready_o, 1'b0);
    @(negedge core_clk_i);
    check("rdy2", req_ready_o, 1'b1);
    // Request stays up until taken; a withdrawn request would break the handshake
    @(negedge core_clk_i);
    req_valid_i = 1'b0;
    check("taken", {cpu_valid_out_o, release_o}, {1'b1, !wr});
    if (wr) begin
      wr_valid_i = 1'b1;
      @(negedge core_clk_i);
      wr_valid_i = 1'b0;
      check("wone", cmd_o, {TYPE_DATA, 1'b0, 1'b1, 6'h0});
    end
  endtask : refuse

  initial begin
    {req_valid_i, req_write_i, req_block_i, wr_valid_i, err, nchk, bchk, gap} = 8'h0;
    {req_size_i, cstate, req_addr_i, wr_data_i} = '0;
    {read_accept_i, write_accept_i, reset_i} = 3'h7;
    repeat (16) @(negedge core_clk_i);
    reset_i = 1'b0;
    repeat (3) @(negedge core_clk_i);
    read_run(1'b0, 3'h7, 36'h8_7654_3218, 1'b0, 1'b0, 1'b0, 1'b0, CS_INVALID);
    read_run(1'b0, 3'h3, 36'h1_0000_0008, 1'b0, 1'b0, 1'b1, 1'b0, CS_DIRTY_EXCL);
    read_run(1'b1, 3'h0, 36'h2_0000_0010, 1'b1, 1'b0, 1'b0, 1'b1, CS_CLEAN_EXCL);
    read_run(1'b1, 3'h1, 36'h3_0000_0018, 1'b0, 1'b1, 1'b1, 1'b0, CS_SHARED);
    read_run(1'b1, 3'h2, 36'h4_0000_0028, 1'b1, 1'b0, 1'b0, 1'b0, CS_DIRTY_SHARED);
    read_run(1'b1, 3'h3, 36'hF_FFFF_FFF8, 1'b0, 1'b0, 1'b0, 1'b1, CS_INVALID);
    for (int s = 0; s < 8; s++) write_run(1'b0, s[2:0], 36'h5_0000_0000 + s);
    write_run(1'b1, 3'h1, 36'h6_0000_0040);
    refuse(1'b0);
    read_run(1'b0, 3'h0, 36'h7_0000_0001, 1'b0, 1'b0, 1'b0, 1'b0, CS_SHARED);
    refuse(1'b1);
    write_run(1'b1, 3'h0, 36'h7_0000_0100);
    repeat (5) @(negedge core_clk_i);
    end_sim();
  end
endmodule : cpu_system_bus_read_protocol_test
